// [logic/maem_matcher.sv]
// Access entry matcher: entry store, per-port frame decision, status and interrupt.
//
// Overview of operation
// - A frame whose deciding entry permits is forwarded and its source address learned.
// - A frame whose deciding entry denies is discarded.
// - A shutdown entry drops the frame and shuts the ingress port down until software clears it.
// - A destination filter set to any leaves the destination address untested.
// - A user defined destination filter demands an exact 48-bit destination match.
// - A source filter set to any leaves the source address untested.
// - A user defined source filter demands an exact source address match.
// - The destination mask bit selects ARP frames whose sender address equals (1) or differs (0).
// - The source mask bit selects ARP frames whose sender address equals (1) or differs (0).
// - Each entry holds a VLAN identifier compared against the frame's VLAN.
// - Each entry holds an include control and a value for the 802.1p priority.
// - The priority mask bit selects equal (1) or differing (0) priorities.
// - EtherType values from 0x05DD to 0xFFFF only are accepted and must match exactly.
// - An entry the hardware cannot install is reported as in conflict.
// - Each entry is bound to a set of ports and only those ports evaluate it.
// - Entries are evaluated in ascending sequence order, lowest first.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
module maem_matcher (
    // Clock and reset.
    input  wire logic                          i_mclk,
    input  wire logic                          i_srst,
    // Register port.
    input  wire logic [maem_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [31:0]                   i_wr_data,
    input  wire logic                          i_wr_en,
    input  wire logic                          i_rd_en,
    output logic      [31:0]                   o_rd_data,
    // Ingress frame from the port logic.
    input  wire logic                          i_frm_valid,
    input  wire logic [2:0]                    i_frm_port,
    input  wire logic [47:0]                   i_frm_dmac,
    input  wire logic [47:0]                   i_frm_smac,
    input  wire logic [47:0]                   i_frm_sha,
    input  wire logic                          i_frm_is_arp,
    input  wire logic [11:0]                   i_frm_vlan,
    input  wire logic [2:0]                    i_frm_pcp,
    input  wire logic [15:0]                   i_frm_etype,
    // Decision.
    output logic                               o_dec_valid,
    output logic                               o_dec_forward,
    output logic                               o_dec_learn,
    output logic                               o_dec_drop,
    output logic                               o_dec_hit,
    output logic      [2:0]                    o_dec_entry,
    output logic      [maem_pkg::NUM_PORTS-1:0] o_port_shut,
    // Interrupt.
    output logic                               o_irq
);
    import maem_pkg::*;

    localparam int N = NUM_ENTRIES;

    // Entry store.
    logic [31:0] ent_ctrl       [N];
    logic [31:0] ent_da_lo      [N];
    logic [15:0] ent_da_hi      [N];
    logic [31:0] ent_sa_lo      [N];
    logic [15:0] ent_sa_hi      [N];
    logic [31:0] ent_match      [N];
    logic [30:0] ent_seq        [N];
    logic [31:0] next_ctrl      [N];
    logic [31:0] next_da_lo     [N];
    logic [15:0] next_da_hi     [N];
    logic [31:0] next_sa_lo     [N];
    logic [15:0] next_sa_hi     [N];
    logic [31:0] next_match     [N];
    logic [30:0] next_seq       [N];

    // Global registers.
    logic [3:0]           status;
    logic [3:0]           next_status;
    logic [3:0]           mask;
    logic [3:0]           next_mask;
    logic                 enable;
    logic                 next_enable;
    logic [NUM_PORTS-1:0] next_port_shut;
    logic [31:0]          next_rd_data;
    logic                 next_irq;

    // Decision registers.
    logic                 next_dec_valid;
    logic                 next_dec_forward;
    logic                 next_dec_learn;
    logic                 next_dec_drop;
    logic                 next_dec_hit;
    logic [2:0]           next_dec_entry;

    // Compare results.
    logic [N-1:0]         hit;
    logic [N-1:0]         conflict;
    logic [N-1:0][30:0]   seq_flat;
    logic                 any_hit;
    logic [2:0]           win_idx;
    logic [3:0]           events;

    // Address decode of the entry window.
    logic                 ent_sel;
    logic [2:0]           ent_idx;
    logic [2:0]           ent_word;

    assign ent_sel  = (i_addr[11:8] == ENT_BASE_HI) && (i_addr[1:0] == 2'b00);
    assign ent_idx  = i_addr[7:5];
    assign ent_word = i_addr[4:2];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ent
            assign seq_flat[g] = ent_seq[g];
            maem_entry_cmp u_cmp (
                .i_ctrl     (ent_ctrl[g]),
                .i_da       ({ent_da_hi[g], ent_da_lo[g]}),
                .i_sa       ({ent_sa_hi[g], ent_sa_lo[g]}),
                .i_match    (ent_match[g]),
                .i_seq      (ent_seq[g]),
                .i_port     (i_frm_port),
                .i_dmac     (i_frm_dmac),
                .i_smac     (i_frm_smac),
                .i_sha      (i_frm_sha),
                .i_is_arp   (i_frm_is_arp),
                .i_vlan     (i_frm_vlan),
                .i_pcp      (i_frm_pcp),
                .i_etype    (i_frm_etype),
                .o_hit      (hit[g]),
                .o_conflict (conflict[g])
            );
        end
    endgenerate

    maem_first_pick #(
        .N (N)
    ) u_pick (
        .i_hit (hit),
        .i_seq (seq_flat),
        .o_any (any_hit),
        .o_idx (win_idx)
    );

    // Entry store next values from register writes.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_ctrl[i]  = ent_ctrl[i];
            next_da_lo[i] = ent_da_lo[i];
            next_da_hi[i] = ent_da_hi[i];
            next_sa_lo[i] = ent_sa_lo[i];
            next_sa_hi[i] = ent_sa_hi[i];
            next_match[i] = ent_match[i];
            next_seq[i]   = ent_seq[i];
        end
        if (i_wr_en && ent_sel) begin
            case (ent_word)
                W_CTRL:  next_ctrl[ent_idx]  = i_wr_data;
                W_DA_LO: next_da_lo[ent_idx] = i_wr_data;
                W_DA_HI: next_da_hi[ent_idx] = i_wr_data[15:0];
                W_SA_LO: next_sa_lo[ent_idx] = i_wr_data;
                W_SA_HI: next_sa_hi[ent_idx] = i_wr_data[15:0];
                W_MATCH: next_match[ent_idx] = i_wr_data;
                W_SEQ:   next_seq[ent_idx]   = i_wr_data[30:0];
                default: next_seq[ent_idx]   = ent_seq[ent_idx];
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        for (int i = 0; i < N; i++) begin
            if (i_srst) begin
                ent_ctrl[i]  <= RST_ZERO;
                ent_da_lo[i] <= RST_ZERO;
                ent_da_hi[i] <= RST_ZERO[15:0];
                ent_sa_lo[i] <= RST_ZERO;
                ent_sa_hi[i] <= RST_ZERO[15:0];
                ent_match[i] <= RST_ZERO;
                ent_seq[i]   <= RST_ZERO[30:0];
            end else begin
                ent_ctrl[i]  <= next_ctrl[i];
                ent_da_lo[i] <= next_da_lo[i];
                ent_da_hi[i] <= next_da_hi[i];
                ent_sa_lo[i] <= next_sa_lo[i];
                ent_sa_hi[i] <= next_sa_hi[i];
                ent_match[i] <= next_match[i];
                ent_seq[i]   <= next_seq[i];
            end
        end
    end

    // Frame decision, shut-down ports and events.
    always_comb begin
        maem_action_t act;
        act              = maem_action_t'(ent_ctrl[win_idx][C_ACT_LO +: 2]);
        next_dec_valid   = i_frm_valid;
        next_dec_forward = 1'b0;
        next_dec_learn   = 1'b0;
        next_dec_drop    = 1'b0;
        next_dec_hit     = 1'b0;
        next_dec_entry   = 3'h0;
        next_port_shut   = o_port_shut;
        events           = 4'h0;
        if (i_wr_en && i_addr == REG_PORTSHUT) begin
            next_port_shut = o_port_shut & ~i_wr_data[NUM_PORTS-1:0];
        end
        if (i_frm_valid) begin
            if (o_port_shut[i_frm_port]) begin
                next_dec_drop    = 1'b1;
                events[S_BLOCK]  = 1'b1;
            end else if (!enable || !any_hit) begin
                next_dec_forward = 1'b1;
                next_dec_learn   = 1'b1;
            end else begin
                next_dec_hit   = 1'b1;
                next_dec_entry = win_idx;
                case (act)
                    MAEM_ACT_PERMIT: begin
                        next_dec_forward = 1'b1;
                        next_dec_learn   = 1'b1;
                        events[S_PERMIT] = 1'b1;
                    end
                    MAEM_ACT_DENY: begin
                        next_dec_drop    = 1'b1;
                        events[S_DENY]   = 1'b1;
                    end
                    MAEM_ACT_SHUTDOWN: begin
                        next_dec_drop    = 1'b1;
                        next_port_shut[i_frm_port] = 1'b1;
                        events[S_SHUT]   = 1'b1;
                    end
                    default: begin
                        next_dec_drop    = 1'b1;
                        events[S_DENY]   = 1'b1;
                    end
                endcase
            end
        end
    end

    // Register reads, sticky status and interrupt.
    always_comb begin
        next_rd_data = RST_ZERO;
        next_status  = status;
        next_mask    = mask;
        next_enable  = enable;
        if (i_rd_en) begin
            if (ent_sel) begin
                case (ent_word)
                    W_CTRL:  next_rd_data = ent_ctrl[ent_idx];
                    W_DA_LO: next_rd_data = ent_da_lo[ent_idx];
                    W_DA_HI: next_rd_data = {16'h0000, ent_da_hi[ent_idx]};
                    W_SA_LO: next_rd_data = ent_sa_lo[ent_idx];
                    W_SA_HI: next_rd_data = {16'h0000, ent_sa_hi[ent_idx]};
                    W_MATCH: next_rd_data = ent_match[ent_idx];
                    W_SEQ:   next_rd_data = {1'b0, ent_seq[ent_idx]};
                    default: next_rd_data = RST_ZERO;
                endcase
            end else begin
                case (i_addr)
                    REG_STATUS: begin
                        next_rd_data = {28'h000_0000, status};
                        next_status  = 4'h0;
                    end
                    REG_MASK:     next_rd_data = {28'h000_0000, mask};
                    REG_PORTSHUT: next_rd_data = {24'h00_0000, o_port_shut};
                    REG_CONFLICT: next_rd_data = {24'h00_0000, conflict};
                    REG_ENABLE:   next_rd_data = {31'h0000_0000, enable};
                    default:      next_rd_data = RST_ZERO;
                endcase
            end
        end
        if (i_wr_en && i_addr == REG_MASK) begin
            next_mask = i_wr_data[3:0];
        end
        if (i_wr_en && i_addr == REG_ENABLE) begin
            next_enable = i_wr_data[0];
        end
        // A new event wins over the clearing read in the same cycle.
        next_status = next_status | events;
        next_irq    = |(next_status & next_mask);
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            status        <= RST_ZERO[3:0];
            mask          <= RST_ZERO[3:0];
            enable        <= RST_ENABLE[0];
            o_port_shut   <= RST_ZERO[NUM_PORTS-1:0];
            o_rd_data     <= RST_ZERO;
            o_irq         <= 1'b0;
            o_dec_valid   <= 1'b0;
            o_dec_forward <= 1'b0;
            o_dec_learn   <= 1'b0;
            o_dec_drop    <= 1'b0;
            o_dec_hit     <= 1'b0;
            o_dec_entry   <= 3'h0;
        end else begin
            status        <= next_status;
            mask          <= next_mask;
            enable        <= next_enable;
            o_port_shut   <= next_port_shut;
            o_rd_data     <= next_rd_data;
            o_irq         <= next_irq;
            o_dec_valid   <= next_dec_valid;
            o_dec_forward <= next_dec_forward;
            o_dec_learn   <= next_dec_learn;
            o_dec_drop    <= next_dec_drop;
            o_dec_hit     <= next_dec_hit;
            o_dec_entry   <= next_dec_entry;
        end
    end

endmodule

// [logic/maem_pkg.sv]
// Package with the register map, field layout and codes of the access entry matcher.
package maem_pkg;

    localparam int NUM_ENTRIES = 8;
    localparam int NUM_PORTS   = 8;
    localparam int ADDR_W      = 12;

    // Global registers.
    localparam logic [11:0] REG_STATUS   = 12'h000;
    localparam logic [11:0] REG_MASK     = 12'h004;
    localparam logic [11:0] REG_PORTSHUT = 12'h008;
    localparam logic [11:0] REG_CONFLICT = 12'h00c;
    localparam logic [11:0] REG_ENABLE   = 12'h010;

    // Entry window: entry index in address bits 7:5, word index in bits 4:2.
    localparam logic [3:0] ENT_BASE_HI = 4'h1;
    localparam logic [2:0] W_CTRL      = 3'h0;
    localparam logic [2:0] W_DA_LO     = 3'h1;
    localparam logic [2:0] W_DA_HI     = 3'h2;
    localparam logic [2:0] W_SA_LO     = 3'h3;
    localparam logic [2:0] W_SA_HI     = 3'h4;
    localparam logic [2:0] W_MATCH     = 3'h5;
    localparam logic [2:0] W_SEQ       = 3'h6;

    // Control word fields.
    localparam int C_VALID    = 0;
    localparam int C_ACT_LO   = 1;
    localparam int C_DA_USER  = 3;
    localparam int C_DA_MASK  = 4;
    localparam int C_SA_USER  = 5;
    localparam int C_SA_MASK  = 6;
    localparam int C_VLAN_EN  = 7;
    localparam int C_PCP_INCL = 8;
    localparam int C_PCP_MASK = 9;
    localparam int C_ETYPE_EN = 10;
    localparam int C_PORT_LO  = 16;

    // Match word fields.
    localparam int M_VLAN_LO  = 0;
    localparam int M_PCP_LO   = 12;
    localparam int M_ETYPE_LO = 16;

    // Status bits.
    localparam int S_PERMIT = 0;
    localparam int S_DENY   = 1;
    localparam int S_SHUT   = 2;
    localparam int S_BLOCK  = 3;

    localparam logic [15:0] ETYPE_MIN  = 16'h05dd;
    localparam logic [15:0] ETYPE_MAX  = 16'hffff;
    localparam logic [30:0] SEQ_MIN    = 31'h0000_0001;
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0001;

    typedef enum logic [1:0] {
        MAEM_ACT_PERMIT   = 2'b00,
        MAEM_ACT_DENY     = 2'b01,
        MAEM_ACT_SHUTDOWN = 2'b10
    } maem_action_t;

endpackage

// [logic/maem_entry_cmp.sv]
// One access entry compared against the frame now offered.
`timescale 1ns/100ps
module maem_entry_cmp (
    // Stored entry.
    input  wire logic [31:0] i_ctrl,
    input  wire logic [47:0] i_da,
    input  wire logic [47:0] i_sa,
    input  wire logic [31:0] i_match,
    input  wire logic [30:0] i_seq,
    // Frame fields.
    input  wire logic [2:0]  i_port,
    input  wire logic [47:0] i_dmac,
    input  wire logic [47:0] i_smac,
    input  wire logic [47:0] i_sha,
    input  wire logic        i_is_arp,
    input  wire logic [11:0] i_vlan,
    input  wire logic [2:0]  i_pcp,
    input  wire logic [15:0] i_etype,
    // Results.
    output logic             o_hit,
    output logic             o_conflict
);
    import maem_pkg::*;

    logic [15:0] etype_val;
    logic        da_ok;
    logic        sa_ok;
    logic        vlan_ok;
    logic        pcp_ok;
    logic        etype_ok;
    logic        bound;

    assign etype_val = i_match[M_ETYPE_LO +: 16];

    // An entry that cannot be installed is flagged and never matches.
    assign o_conflict = i_ctrl[C_VALID]
        && ((i_ctrl[C_ETYPE_EN] && (etype_val < ETYPE_MIN || etype_val > ETYPE_MAX))
            || i_seq < SEQ_MIN);

    always_comb begin
        da_ok    = 1'b1;
        sa_ok    = 1'b1;
        if (i_ctrl[C_DA_USER]) begin
            da_ok = (i_dmac == i_da);
            if (i_is_arp) begin
                da_ok = da_ok && ((i_sha == i_da) == i_ctrl[C_DA_MASK]);
            end
        end
        if (i_ctrl[C_SA_USER]) begin
            sa_ok = (i_smac == i_sa);
            if (i_is_arp) begin
                sa_ok = sa_ok && ((i_sha == i_sa) == i_ctrl[C_SA_MASK]);
            end
        end
        vlan_ok  = !i_ctrl[C_VLAN_EN] || (i_vlan == i_match[M_VLAN_LO +: 12]);
        pcp_ok   = !i_ctrl[C_PCP_INCL]
            || ((i_pcp == i_match[M_PCP_LO +: 3]) == i_ctrl[C_PCP_MASK]);
        etype_ok = !i_ctrl[C_ETYPE_EN] || (i_etype == etype_val);
    end

    assign bound = i_ctrl[C_PORT_LO + i_port];

    assign o_hit = i_ctrl[C_VALID] && !o_conflict && bound
        && da_ok && sa_ok && vlan_ok && pcp_ok && etype_ok;

endmodule

// [logic/maem_first_pick.sv]
// Picks the hitting entry with the lowest sequence number.
`timescale 1ns/100ps
module maem_first_pick #(
    parameter int N = 8
) (
    // Candidates.
    input  wire logic [N-1:0]         i_hit,
    input  wire logic [N-1:0][30:0]   i_seq,
    // Winner.
    output logic                      o_any,
    output logic [$clog2(N)-1:0]      o_idx
);
    logic [30:0] best_seq;

    // Ties go to the lower entry index so the choice is stable.
    always_comb begin
        o_any    = 1'b0;
        o_idx    = '0;
        best_seq = '1;
        for (int i = 0; i < N; i++) begin
            if (i_hit[i] && (!o_any || i_seq[i] < best_seq)) begin
                o_any    = 1'b1;
                o_idx    = i[$clog2(N)-1:0];
                best_seq = i_seq[i];
            end
        end
    end

endmodule

// [verif/maem_checker.sv]
// Checker of decision timing, port shutdown and read data timing of the matcher.
`timescale 1ns/100ps
module maem_checker (
    // Clock and reset.
    input wire logic                            i_mclk,
    input wire logic                            i_srst,
    // Register port.
    input wire logic [maem_pkg::ADDR_W-1:0]     i_addr,
    input wire logic                            i_wr_en,
    input wire logic                            i_rd_en,
    input wire logic [31:0]                     o_rd_data,
    // Frame and decision.
    input wire logic                            i_frm_valid,
    input wire logic [2:0]                      i_frm_port,
    input wire logic                            o_dec_valid,
    input wire logic                            o_dec_forward,
    input wire logic                            o_dec_learn,
    input wire logic                            o_dec_drop,
    input wire logic                            o_dec_hit,
    input wire logic [2:0]                      o_dec_entry,
    input wire logic [maem_pkg::NUM_PORTS-1:0]  o_port_shut
);
    import maem_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    a_dec_follows: assert property (i_frm_valid |=> o_dec_valid)
        else $error("decision missing");
    a_dec_quiet: assert property (!i_frm_valid |=> !o_dec_valid && !o_dec_forward)
        else $error("decision without frame");
    a_permit_learns: assert property (o_dec_valid && o_dec_forward |-> o_dec_learn)
        else $error("forward not learned");
    a_drop_alone: assert property (o_dec_drop |-> o_dec_valid && !o_dec_forward && !o_dec_learn)
        else $error("drop also forwarded");
    a_miss_forwards: assert property (i_frm_valid && !o_port_shut[i_frm_port] ##1 !o_dec_hit
        |-> o_dec_forward && o_dec_entry == 3'h0)
        else $error("miss not forwarded");
    a_shut_drops: assert property (i_frm_valid && o_port_shut[i_frm_port] |=> o_dec_drop)
        else $error("shut port not dropped");
    a_shut_holds: assert property (!(i_wr_en && i_addr == REG_PORTSHUT)
        |=> (o_port_shut & $past(o_port_shut)) == $past(o_port_shut))
        else $error("shut cleared without write");
    a_shut_cause: assert property (!i_frm_valid |=> (o_port_shut & ~$past(o_port_shut)) == 8'h00)
        else $error("shut without frame");
    a_read_stands: assert property (!i_rd_en |=> o_rd_data == 32'h0000_0000)
        else $error("read data without read");

    c_permit: cover property (o_dec_valid && o_dec_hit && o_dec_forward);
    c_deny: cover property (o_dec_valid && o_dec_hit && o_dec_drop);
    c_shut: cover property (o_port_shut != 8'h00);
endmodule

bind maem_matcher maem_checker chk_u (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_frm_valid(i_frm_valid),
    .i_frm_port(i_frm_port), .o_dec_valid(o_dec_valid), .o_dec_forward(o_dec_forward),
    .o_dec_learn(o_dec_learn), .o_dec_drop(o_dec_drop), .o_dec_hit(o_dec_hit),
    .o_dec_entry(o_dec_entry), .o_port_shut(o_port_shut)
);

// [verif/maem_ingress_model.sv]
// Model of the port ingress path that offers frame headers to the matcher.
`timescale 1ns/100ps
module maem_ingress_model (
    // Clock.
    input  wire logic       i_mclk,
    // Frame header.
    output logic            o_frm_valid,
    output logic [2:0]      o_frm_port,
    output logic [47:0]     o_frm_dmac,
    output logic [47:0]     o_frm_smac,
    output logic [47:0]     o_frm_sha,
    output logic            o_frm_is_arp,
    output logic [11:0]     o_frm_vlan,
    output logic [2:0]      o_frm_pcp,
    output logic [15:0]     o_frm_etype
);
    logic [178:0] hdr;

    assign {o_frm_port, o_frm_dmac, o_frm_smac, o_frm_sha, o_frm_is_arp,
            o_frm_vlan, o_frm_pcp, o_frm_etype} = hdr;

    initial begin
        o_frm_valid = 1'b0;
        hdr = '0;
    end

    // Fields are not held after the frame, so their inverse is driven to expose stale use.
    task automatic offer(input logic [178:0] h);
        @(posedge i_mclk);
        o_frm_valid <= 1'b1;
        hdr <= h;
        @(posedge i_mclk);
        o_frm_valid <= 1'b0;
        hdr <= ~h;
    endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the access entry matcher.
`timescale 1ns/100ps
module tb_top;
    import maem_pkg::*;
    localparam logic [47:0] A = 48'h0011_2233_4455;
    localparam logic [47:0] B = 48'h0011_2233_4466;
    logic        i_mclk, i_srst, i_wr_en, i_rd_en;
    logic [11:0] i_addr;
    logic [31:0] i_wr_data, o_rd_data;
    logic        fv, fa, dv, df, dl, dd, dh, irq;
    logic [2:0]  fp, fq, de;
    logic [47:0] fd, fs, fh;
    logic [11:0] fvl;
    logic [15:0] fe;
    logic [7:0]  shut;
    int          num_errors = 0;
    int          compares = 0;

    maem_ingress_model partner_u (.i_mclk(i_mclk), .o_frm_valid(fv), .o_frm_port(fp),
        .o_frm_dmac(fd), .o_frm_smac(fs), .o_frm_sha(fh), .o_frm_is_arp(fa),
        .o_frm_vlan(fvl), .o_frm_pcp(fq), .o_frm_etype(fe));
    maem_matcher dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
        .i_frm_valid(fv), .i_frm_port(fp), .i_frm_dmac(fd), .i_frm_smac(fs), .i_frm_sha(fh),
        .i_frm_is_arp(fa), .i_frm_vlan(fvl), .i_frm_pcp(fq), .i_frm_etype(fe),
        .o_dec_valid(dv), .o_dec_forward(df), .o_dec_learn(dl), .o_dec_drop(dd),
        .o_dec_hit(dh), .o_dec_entry(de), .o_port_shut(shut), .o_irq(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd_en <= 1'b0;
        #1;
        check(o_rd_data, exp);
    endtask

    task automatic ent(input logic [11:0] b, input logic [31:0] c, input logic [47:0] da,
                       input logic [47:0] sa, input logic [31:0] m, input logic [31:0] sq);
        wr(b, c);
        wr(b + 12'h004, da[31:0]);
        wr(b + 12'h008, {16'h0000, da[47:32]});
        wr(b + 12'h00c, sa[31:0]);
        wr(b + 12'h010, {16'h0000, sa[47:32]});
        wr(b + 12'h014, m);
        wr(b + 12'h018, sq);
    endtask

    // Expected x is {drop, hit, entry}; forward and learn are the inverse of drop.
    task automatic go(input logic [2:0] p, input logic [4:0] x, input logic [47:0] d = B,
                      input logic [47:0] s = B, input logic [47:0] h = B, input logic a = 1'b0,
                      input logic [11:0] v = 12'h000, input logic [2:0] q = 3'h0,
                      input logic [15:0] t = 16'h0800);
        partner_u.offer({p, d, s, h, a, v, q, t});
        #1;
        check({24'h00_0000, dv, df, dl, dd, dh, de},
              {24'h00_0000, 1'b1, ~x[4], ~x[4], x[4], x[3:0]});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial begin
        #50_000;
        num_errors++;
        complete_run();
    end

    initial begin
        i_srst = 1'b1;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_addr = 12'h000;
        i_wr_data = 32'h0000_0000;
        repeat (4) @(posedge i_mclk);
        i_srst <= 1'b0;
        rd(REG_STATUS, 32'h0000_0000);
        rd(REG_MASK, 32'h0000_0000);
        rd(REG_PORTSHUT, 32'h0000_0000);
        rd(REG_CONFLICT, 32'h0000_0000);
        rd(REG_ENABLE, 32'h0000_0001);
        rd(12'h020, 32'h0000_0000);
        rd(12'h11c, 32'h0000_0000);
        go(3'h0, 5'h00, A);
        $display("test reset done");
        ent(12'h100, 32'h0001_0009, A, B, 32'h0000_0000, 32'h0000_0005);
        ent(12'h120, 32'h0002_0003, B, B, 32'h0000_0000, 32'h0000_0003);
        go(3'h0, 5'h08, A);
        go(3'h0, 5'h00);
        go(3'h1, 5'h19, B, A);
        go(3'h2, 5'h00, A);
        rd(REG_STATUS, 32'h0000_0003);
        rd(REG_STATUS, 32'h0000_0000);
        $display("test actions done");
        ent(12'h140, 32'h0001_0083, B, B, 32'h0000_0007, 32'h0000_0002);
        go(3'h0, 5'h1a, A, B, B, 1'b0, 12'h007);
        go(3'h0, 5'h08, A, B, B, 1'b0, 12'h008);
        wr(12'h140, 32'h0000_0000);
        $display("test order done");
        ent(12'h160, 32'h0001_0063, A, A, 32'h0000_0000, 32'h0000_0001);
        go(3'h0, 5'h1b, B, A);
        go(3'h0, 5'h00);
        go(3'h0, 5'h1b, B, A, A, 1'b1);
        go(3'h0, 5'h00, B, A, B, 1'b1);
        wr(12'h160, 32'h0001_0023);
        go(3'h0, 5'h1b, B, A, B, 1'b1);
        go(3'h0, 5'h00, B, A, A, 1'b1);
        wr(12'h160, 32'h0001_001b);
        go(3'h0, 5'h1b, A, B, A, 1'b1);
        go(3'h0, 5'h08, A, B, B, 1'b1);
        wr(12'h160, 32'h0000_0000);
        $display("test address filters done");
        ent(12'h180, 32'h0001_0103, B, B, 32'h0000_3000, 32'h0000_0001);
        go(3'h0, 5'h00, B, B, B, 1'b0, 12'h000, 3'h3);
        go(3'h0, 5'h1c, B, B, B, 1'b0, 12'h000, 3'h4);
        wr(12'h180, 32'h0001_0303);
        go(3'h0, 5'h1c, B, B, B, 1'b0, 12'h000, 3'h3);
        go(3'h0, 5'h00, B, B, B, 1'b0, 12'h000, 3'h4);
        wr(12'h180, 32'h0000_0000);
        $display("test priority done");
        ent(12'h1a0, 32'h0001_0403, B, B, 32'h0800_0000, 32'h0000_0001);
        ent(12'h1c0, 32'h0001_0403, B, B, 32'h05dc_0000, 32'h0000_0001);
        go(3'h0, 5'h1d);
        go(3'h0, 5'h00, B, B, B, 1'b0, 12'h000, 3'h0, 16'h0806);
        rd(REG_CONFLICT, 32'h0000_0040);
        go(3'h0, 5'h00, B, B, B, 1'b0, 12'h000, 3'h0, 16'h05dc);
        wr(12'h1d4, 32'h05dd_0000);
        rd(REG_CONFLICT, 32'h0000_0000);
        go(3'h0, 5'h1e, B, B, B, 1'b0, 12'h000, 3'h0, 16'h05dd);
        wr(12'h1e0, 32'h0000_0001);
        rd(REG_CONFLICT, 32'h0000_0080);
        wr(12'h1a0, 32'h0000_0000);
        wr(12'h1c0, 32'h0000_0000);
        wr(12'h1e0, 32'h0000_0000);
        $display("test ethertype done");
        rd(REG_STATUS, 32'h0000_0003);
        wr(REG_MASK, 32'h0000_0004);
        wr(12'h120, 32'h0002_0005);
        go(3'h1, 5'h19);
        check({24'h00_0000, shut}, 32'h0000_0002);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        go(3'h1, 5'h10);
        rd(REG_STATUS, 32'h0000_000c);
        wr(REG_PORTSHUT, 32'h0000_0002);
        #1;
        check({23'h00_0000, irq, shut}, 32'h0000_0000);
        wr(12'h120, 32'h0002_0003);
        $display("test shutdown done");
        wr(REG_ENABLE, 32'h0000_0000);
        go(3'h1, 5'h00);
        wr(REG_ENABLE, 32'h0000_0001);
        go(3'h1, 5'h19);
        $display("test enable done");
        complete_run();
    end
endmodule
